//--- lcdd_params.svh
// Constants for the LCD display memory driver
`ifndef LCDD_PARAMS_SVH
`define LCDD_PARAMS_SVH
`define LCDD_BANK_SELECT_ADDR 8'h04
`define LCDD_BANK_SELECT_RST  8'h00
`define LCDD_BANK_LCD         8'h01
`define LCDD_DISP_FIRST       8'h40
`define LCDD_DISP_LAST        8'h52
`define LCDD_DISP_BYTES       19
`define LCDD_SYS_DIV          2'h3
`endif

//--- lcdd_pkg.sv
// Types for the LCD display memory driver
package lcdd_pkg;
  typedef enum logic [1:0] {
    LCDD_DUTY_2 = 2'h0,
    LCDD_DUTY_3 = 2'h1,
    LCDD_DUTY_4 = 2'h2
  } lcdd_duty_e;
  typedef enum logic [1:0] {
    LCDD_SRC_SYS4 = 2'h0,
    LCDD_SRC_RTC  = 2'h1,
    LCDD_SRC_WDT  = 2'h2
  } lcdd_src_e;
  typedef enum logic [3:0] {
    LCDD_PH0 = 4'h1,
    LCDD_PH1 = 4'h2,
    LCDD_PH2 = 4'h4,
    LCDD_PH3 = 4'h8
  } lcdd_phase_e;
  // Drive level code: 0 = ground, 3 = full LCD voltage, 1/2 intermediate
  typedef logic [1:0] lcdd_level_t;
endpackage : lcdd_pkg

//--- lcdd_driver.sv
// LCD display memory, bank switch and common/segment scan driver
// Core side
//   The core presents one strobe cycle per data memory access: mem_wr or
//   mem_rd, with mem_addr, mem_wdata and mem_indirect standing beside it.
//   A strobe counts only on an edge with clk_en high.
//   Read data and the display hit flag appear one cycle after the strobe.
//   mem_hit_lcd is a one-cycle pulse that tells the core not to touch its
//   own general memory byte at the same address.
//   mem_rdata holds its value until the next read that the block answers.
//   Reads of general memory leave mem_rdata untouched; the core muxes.
//
// Bank register
//   The bank register answers at its own address whatever the access mode,
//   so direct writes can switch banks before a pointer access.
//   Only the value 01H opens the display window; any other value closes it.
//
// Scan side
//   Source ticks come from system/4 or from a rising edge of one of the two
//   slow oscillators, sampled once against the core clock.
//   The oscillators must be far slower than the core clock; a pulse shorter
//   than one clock period can be lost, which only slows the scan.
//   One common phase lasts 2^(sel+2) source ticks.
//   Polarity flips after the last common of a frame, so every pixel sees an
//   equal and opposite swing over two frames and the net DC is zero.
//
// Level code on the drive outputs
//   0 ground, 3 full panel voltage, 1 and 2 the intermediate levels.
//   In 1/2 bias only level 1 is used as intermediate.
//   In 1/3 bias the idle commons and the off segments sit one third apart
//   from each other, so an off pixel sees one third of the swing.
//
// Halt
//   With the halt option clear the divider stops and every pin goes to
//   ground, so the glass sees no voltage while the core sleeps.
//   Display memory keeps its contents through halt.
//
// Limitations
//   opt_div_sel of seven is outside the documented range and divides by 256, as six does.
//   Option inputs are level signals; changing them mid-frame can stretch
//   one phase but never leaves the sequencer in an unused state.
`timescale 1ns/10ps
`include "lcdd_params.svh"
module lcdd_driver
  import lcdd_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     clk_en,
  input  wire logic                     mem_wr,
  input  wire logic                     mem_rd,
  input  wire logic                     mem_indirect,
  input  wire logic [7:0]               mem_addr,
  input  wire logic [7:0]               mem_wdata,
  input  wire lcdd_pkg::lcdd_duty_e     opt_duty,
  input  wire logic                     opt_bias_third,
  input  wire lcdd_pkg::lcdd_src_e      opt_src,
  input  wire logic [2:0]               opt_div_sel,
  input  wire logic                     opt_on_in_halt,
  input  wire logic                     cpu_halt,
  input  wire logic                     timekeeping_oscillator,
  input  wire logic                     watchdog_oscillator,
  output logic [7:0]                    mem_rdata,
  output logic                          mem_hit_lcd,
  output logic [7:0]                    bank_select,
  output lcdd_pkg::lcdd_level_t         com_level [4],
  output lcdd_pkg::lcdd_level_t         seg_level [19]
);
  import lcdd_pkg::*;

  // Display memory array
  logic [7:0] disp_q [`LCDD_DISP_BYTES];
  logic [7:0] disp_d [`LCDD_DISP_BYTES];
  logic [7:0] bank_q, bank_d;
  logic [7:0] rdata_q, rdata_d;
  logic       hit_q, hit_d;

  // Address falls into display window
  function automatic logic in_disp(input logic [7:0] a);
    in_disp = (a >= `LCDD_DISP_FIRST) && (a <= `LCDD_DISP_LAST);
  endfunction : in_disp

  logic lcd_sel;
  logic [4:0] disp_idx;
  assign disp_idx = 5'(mem_addr - `LCDD_DISP_FIRST);
  // Only pointer-one indirect with bank 1 reaches display bytes
  assign lcd_sel = in_disp(mem_addr) && mem_indirect
                   && (bank_q == `LCDD_BANK_LCD);

  // Register and display memory next state
  always_comb begin
    disp_d  = disp_q;
    bank_d  = bank_q;
    rdata_d = rdata_q;
    hit_d   = 1'b0;
    if (mem_wr && mem_addr == `LCDD_BANK_SELECT_ADDR) begin
      bank_d = mem_wdata;
    end
    if (lcd_sel && (mem_wr || mem_rd)) begin
      hit_d = 1'b1; // Tells the core to leave general memory alone
      if (mem_wr) begin
        disp_d[disp_idx] = mem_wdata;
      end
      if (mem_rd) begin
        rdata_d = disp_q[disp_idx];
      end
    end else if (mem_rd && mem_addr == `LCDD_BANK_SELECT_ADDR) begin
      rdata_d = bank_q;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bank_q  <= `LCDD_BANK_SELECT_RST;
      rdata_q <= 8'h00;
      hit_q   <= 1'b0;
      for (int i = 0; i < `LCDD_DISP_BYTES; i++) begin
        disp_q[i] <= 8'h00;
      end
    end else if (clk_en) begin
      bank_q  <= bank_d;
      rdata_q <= rdata_d;
      hit_q   <= hit_d;
      disp_q  <= disp_d;
    end
  end

  assign mem_rdata   = rdata_q;
  assign mem_hit_lcd = hit_q;
  assign bank_select = bank_q;

  // Source clocks: oscillators are sampled as plain inputs, so they must be
  // much slower than the 25 MHz core clock; edges are taken from one stage.
  logic [1:0] sys_div_q, sys_div_d;
  logic       rtc_q, rtc_d, wdt_q, wdt_d;
  logic       src_tick;
  logic [7:0] scan_div_q, scan_div_d;
  logic       scan_tick;
  logic       run;

  assign run = !cpu_halt || opt_on_in_halt;

  always_comb begin
    sys_div_d = sys_div_q + 2'h1;
    rtc_d     = timekeeping_oscillator;
    wdt_d     = watchdog_oscillator;
    case (opt_src)
      LCDD_SRC_SYS4: src_tick = (sys_div_q == `LCDD_SYS_DIV);
      LCDD_SRC_RTC:  src_tick = timekeeping_oscillator && !rtc_q;
      LCDD_SRC_WDT:  src_tick = watchdog_oscillator && !wdt_q;
      default:       src_tick = 1'b0;
    endcase
    scan_div_d = scan_div_q;
    scan_tick  = 1'b0;
    if (run && src_tick) begin
      // Divide by 2^(sel+2): seven choices from 4 to 256
      if (scan_div_q == 8'((9'h004 << opt_div_sel) - 9'h001)) begin
        scan_div_d = 8'h00;
        scan_tick  = 1'b1;
      end else begin
        scan_div_d = scan_div_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sys_div_q  <= 2'h0;
      rtc_q      <= 1'b0;
      wdt_q      <= 1'b0;
      scan_div_q <= 8'h00;
    end else if (clk_en) begin
      sys_div_q  <= sys_div_d;
      rtc_q      <= rtc_d;
      wdt_q      <= wdt_d;
      scan_div_q <= scan_div_d;
    end
  end

  // Common phase sequencer and frame polarity
  lcdd_phase_e phase_q, phase_d;
  logic        pol_q, pol_d;
  logic        last_phase;

  always_comb begin
    phase_d = phase_q;
    pol_d   = pol_q;
    case (phase_q)
      LCDD_PH1: last_phase = (opt_duty == LCDD_DUTY_2);
      LCDD_PH2: last_phase = (opt_duty == LCDD_DUTY_3);
      LCDD_PH3: last_phase = 1'b1;
      default:  last_phase = 1'b0;
    endcase
    if (scan_tick) begin
      if (last_phase) begin
        phase_d = LCDD_PH0;
        pol_d   = !pol_q;
      end else begin
        case (phase_q)
          LCDD_PH0: phase_d = LCDD_PH1;
          LCDD_PH1: phase_d = LCDD_PH2;
          LCDD_PH2: phase_d = LCDD_PH3;
          default:  phase_d = LCDD_PH0;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      phase_q <= LCDD_PH0;
      pol_q   <= 1'b0;
    end else if (clk_en) begin
      phase_q <= phase_d;
      pol_q   <= pol_d;
    end
  end

  // Level helpers: full, ground and the intermediate levels per bias, one in 1/2 bias and two in 1/3 bias
  function automatic lcdd_level_t lvl(input logic high, input logic pol);
    lvl = (high ^ pol) ? 2'h3 : 2'h0;
  endfunction : lvl

  logic [1:0]  cur_com;
  lcdd_level_t com_d [4];
  lcdd_level_t seg_d [19];
  lcdd_level_t com_q [4];
  lcdd_level_t seg_q [19];
  lcdd_level_t mid_com, mid_seg_on, mid_seg_off;

  always_comb begin
    case (phase_q)
      LCDD_PH1: cur_com = 2'h1;
      LCDD_PH2: cur_com = 2'h2;
      LCDD_PH3: cur_com = 2'h3;
      default:  cur_com = 2'h0;
    endcase
    // 1/2 bias: everything idle sits at mid. 1/3 bias: unselected commons
    // at 1/3 or 2/3, off segments at 2/3 or 1/3 so off pixels see only Vlcd/3.
    if (opt_bias_third) begin
      mid_com     = pol_q ? 2'h2 : 2'h1;
      mid_seg_on  = pol_q ? 2'h3 : 2'h0;
      mid_seg_off = pol_q ? 2'h1 : 2'h2;
    end else begin
      mid_com     = 2'h1;
      mid_seg_on  = pol_q ? 2'h3 : 2'h0;
      mid_seg_off = 2'h1;
    end
    for (int c = 0; c < 4; c++) begin
      com_d[c] = (2'(c) == cur_com) ? lvl(1'b1, pol_q) : mid_com;
    end
    for (int s = 0; s < 19; s++) begin
      // Pixel on drives segment opposite to its common
      seg_d[s] = disp_q[s][cur_com] ? mid_seg_on : mid_seg_off;
    end
    // Fourth common reuses the last segment pin
    if (opt_duty == LCDD_DUTY_4) begin
      seg_d[18] = com_d[3];
    end
    if (!run) begin
      // Halted with display off: all pins at ground, panel sees no voltage
      for (int c = 0; c < 4; c++) begin
        com_d[c] = 2'h0;
      end
      for (int s = 0; s < 19; s++) begin
        seg_d[s] = 2'h0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int c = 0; c < 4; c++) begin
        com_q[c] <= 2'h0;
      end
      for (int s = 0; s < 19; s++) begin
        seg_q[s] <= 2'h0;
      end
    end else if (clk_en) begin
      com_q <= com_d;
      seg_q <= seg_d;
    end
  end

  assign com_level = com_q;
  assign seg_level = seg_q;
endmodule : lcdd_driver

//--- lcdd_monitor.sv
// Port checker for the LCD display memory driver
`timescale 1ns/10ps
module lcdd_monitor
  import lcdd_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  rst,
  input wire logic                  clk_en,
  input wire logic                  mem_wr,
  input wire logic                  mem_rd,
  input wire logic                  mem_indirect,
  input wire logic [7:0]            mem_addr,
  input wire logic [7:0]            mem_wdata,
  input wire lcdd_pkg::lcdd_duty_e  opt_duty,
  input wire logic                  opt_bias_third,
  input wire logic                  opt_on_in_halt,
  input wire logic                  cpu_halt,
  input wire logic [7:0]            mem_rdata,
  input wire logic                  mem_hit_lcd,
  input wire logic [7:0]            bank_select,
  input wire lcdd_pkg::lcdd_level_t com_level [4],
  input wire lcdd_pkg::lcdd_level_t seg_level [19]
);
  logic stb, disp, off;
  // Outputs lag the options, so option conditions look two cycles back
  assign stb = clk_en && (mem_wr || mem_rd);
  assign disp = mem_addr >= 8'h40 && mem_addr <= 8'h52;
  assign off = cpu_halt && !opt_on_in_halt && clk_en;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_hit;
    stb && mem_indirect && disp && bank_select == 8'h01 |=> mem_hit_lcd;
  endproperty
  a_hit: assert property (p_hit) else $error("display hit missing");
  property p_direct; stb && !mem_indirect |=> !mem_hit_lcd; endproperty
  a_direct: assert property (p_direct) else $error("direct hit");
  property p_bank; stb && bank_select != 8'h01 |=> !mem_hit_lcd; endproperty
  a_bank: assert property (p_bank) else $error("hit outside bank one");
  property p_bank_wr;
    clk_en && mem_wr && mem_addr == 8'h04 |=> bank_select == $past(mem_wdata);
  endproperty
  a_bank_wr: assert property (p_bank_wr) else $error("bank write lost");
  property p_bank_rd;
    clk_en && mem_rd && !mem_wr && mem_addr == 8'h04 |=> mem_rdata == bank_select;
  endproperty
  a_bank_rd: assert property (p_bank_rd) else $error("bank read wrong");
  property p_pin;
    $past(opt_duty) == LCDD_DUTY_4 && $past(opt_duty, 2) == LCDD_DUTY_4
      |-> seg_level[18] == com_level[3];
  endproperty
  a_pin: assert property (p_pin) else $error("last pin not a common");
  property p_halt; off ##1 off ##1 off |-> com_level[0] == 2'h0 && seg_level[0] == 2'h0;
  endproperty
  a_halt: assert property (p_halt) else $error("drive during halt");
  property p_bias;
    !$past(opt_bias_third) && !$past(opt_bias_third, 2)
      |-> com_level[1] != 2'h2 && seg_level[0] != 2'h2;
  endproperty
  a_bias: assert property (p_bias) else $error("third level in half bias");
  c_hit: cover property (mem_hit_lcd);
  c_halt: cover property (off ##1 off ##1 off);
  c_four: cover property (opt_duty == LCDD_DUTY_4 && com_level[3] == 2'h3);
endmodule : lcdd_monitor
bind lcdd_driver lcdd_monitor u_lcdd_monitor (.*);

//--- lcdd_panel.sv
// Glass panel model: records which pixels see full drive swing
`timescale 1ns/10ps
module lcdd_panel
  import lcdd_pkg::*;
(
  input wire logic                  clock,
  input wire lcdd_pkg::lcdd_level_t com_level [4],
  input wire lcdd_pkg::lcdd_level_t seg_level [19],
  output logic [3:0]                lit [19]
);
  // Only a common at an extreme level, selected or grounded in halt, updates its pixels
  always_ff @(posedge clock) begin
    for (int k = 0; k < 19; k++) begin
      for (int j = 0; j < 4; j++) begin
        if (com_level[j][1] == com_level[j][0]) begin
          lit[k][j] <= (com_level[j] ^ seg_level[k]) == 2'h3;
        end
      end
    end
  end
endmodule : lcdd_panel

//--- tb_lcdd_driver.sv
// Self-checking bench for the LCD display memory driver
`timescale 1ns/10ps
module tb_lcdd_driver;
  import lcdd_pkg::*;
  logic clock = 0, rst = 1, clk_en = 1, mem_wr = 0, mem_rd = 0, mem_indirect = 0;
  logic opt_bias_third = 0, opt_on_in_halt = 0, cpu_halt = 0, rd_p = 0, mem_hit_lcd;
  logic timekeeping_oscillator = 0, watchdog_oscillator = 0;
  logic [7:0] mem_addr = 0, mem_wdata = 0, mem_rdata, bank_select, img [19];
  logic [2:0] opt_div_sel = 0;
  logic [3:0] mask, lit [19];
  lcdd_duty_e opt_duty = LCDD_DUTY_2;
  lcdd_src_e opt_src = LCDD_SRC_SYS4;
  lcdd_level_t com_level [4], seg_level [19];
  logic [7:0] exp_q [$];
  int num_errors = 0, comparisons = 0, seed = 16198;
  lcdd_driver u_lcdd_driver (.*);
  lcdd_panel u_lcdd_panel (.*);
  // Clock and two slow oscillators off the clock edges
  always #20 clock = ~clock;
  initial #5 forever #140 timekeeping_oscillator = ~timekeeping_oscillator;
  initial #5 forever #100 watchdog_oscillator = ~watchdog_oscillator;
  task automatic check(input logic [7:0] seen, want, input string what);
    comparisons++;
    if (seen !== want) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic conclude;
    if (num_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // One strobe cycle; the answer is valid when this returns
  task automatic acc(input logic wr, ind, input logic [7:0] a, d);
    @(posedge clock);
    #1;
    {mem_wr, mem_rd, mem_indirect, mem_addr, mem_wdata} = {wr, !wr, ind, a, d};
    @(posedge clock);
    #1;
    {mem_wr, mem_rd} = 2'b00;
  endtask : acc
  // Read data watcher: oldest note against the answer
  always @(posedge clock) rd_p <= mem_rd & clk_en & !rst;
  always @(negedge clock) if (rd_p) check(mem_rdata, exp_q.pop_front(), "mem_rdata");
  initial begin
    repeat (3) @(posedge clock);
    #1 rst = 0;
    check(bank_select, 8'h00, "bank_select");
    acc(1, 0, 8'h04, 8'h01);
    for (int k = 0; k < 19; k++) begin
      img[k] = 8'($random(seed));
      acc(1, 1, 8'h40 + 8'(k), img[k]);
      check(8'(mem_hit_lcd), 8'h01, "mem_hit_lcd");
    end
    acc(1, 0, 8'h45, ~img[5]);
    check(8'(mem_hit_lcd), 8'h00, "direct hit");
    acc(1, 0, 8'h04, 8'h00);
    acc(1, 1, 8'h46, ~img[6]);
    check(8'(mem_hit_lcd), 8'h00, "bank zero hit");
    exp_q.push_back(8'h00);
    acc(0, 0, 8'h04, 8'h00);
    acc(1, 0, 8'h04, 8'h01);
    for (int k = 0; k < 19; k++) begin
      exp_q.push_back(img[k]);
      acc(0, 1, 8'h40 + 8'(k), 8'h00);
    end
    exp_q.push_back(img[18]);
    acc(0, 1, 8'h53, 8'h00);
    check(8'(mem_hit_lcd), 8'h00, "past window");
    cpu_halt = 1;
    repeat (20) @(posedge clock);
    #1;
    for (int k = 0; k < 19; k++) check(8'(lit[k]), 8'h00, "halt lit");
    opt_on_in_halt = 1;
    for (int m = 0; m < 12; m++) begin
      opt_duty = lcdd_duty_e'(m % 3);
      opt_bias_third = 1'(m % 2);
      opt_src = lcdd_src_e'(m / 4);
      opt_div_sel = 3'(m % 7);
      cpu_halt = m > 8;
      mask = opt_duty == LCDD_DUTY_2 ? 4'h3 : opt_duty == LCDD_DUTY_3 ? 4'h7 : 4'hf;
      repeat (64 * (4 << opt_div_sel)) @(posedge clock);
      #1;
      for (int k = 0; k < 19; k++) begin
        if (k < 18 || opt_duty != LCDD_DUTY_4)
          check(8'(lit[k] & mask), 8'(img[k][3:0] & mask), "lit");
      end
    end
    conclude();
  end
endmodule : tb_lcdd_driver
